// [shared/adc_port_pkg.sv]
package adc_port_pkg;

    // Word sizes
    localparam int CMD_W = 8;
    localparam int RESULT_W = 16;

    // Command byte fields
    localparam int READ_BIT = 3;
    localparam int REG_LSB = 4;
    localparam int REG_W = 2;
    localparam logic [1:0] SETUP_REG = 2'h1;
    localparam logic [7:0] READ_CMD = 8'h38;

    // Setup byte fields
    localparam int CLK_BIT = 2;
    localparam int STBY_BIT = 6;
    localparam logic [7:0] SETUP_RESET = 8'h00;

    // Result codes
    localparam int signed FS_POS = 32767;
    localparam int signed FS_NEG = -32768;
    localparam logic [15:0] CODE_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] CODE_ALL_ZEROS = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;

    // Converter timing, in master clock periods
    localparam int RDY_HIGH_CYCLES = 500;
    localparam int UPDATE_CYCLES_DEF = 2000;

    // Host clocking
    localparam int SYS_HZ = 40_000_000;
    localparam int SYS_PERIOD_NS = 25;
    localparam int MCLK_MIN_HZ = 400_000;
    localparam int MCLK_MAX_HZ = 2_500_000;
    localparam int CLK_SEL_HZ = 2_000_000;
    localparam int MCLK_HALF_CYCLES = (SYS_HZ + 2 * MCLK_MAX_HZ - 1) / (2 * MCLK_MAX_HZ);
    localparam int CS_SETUP_NS = 120;
    localparam int CS_SETUP_CYCLES = (CS_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int SCLK_HALF_DEF = 100;

endpackage : adc_port_pkg

// [shared/adc_link_if.sv]
`timescale 1ns/100ps
interface adc_link_if;
    logic master_clk;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;
    logic result_ready_n;

    // Released data line idles high
    assign dout_line = dout_oe ? dout : 1'b1;

    modport host (
        output master_clk,
        output cs_n,
        output sclk,
        output din,
        input dout_line,
        input result_ready_n
    );

    modport dev (
        input master_clk,
        input cs_n,
        input sclk,
        input din,
        output dout,
        output dout_oe,
        output result_ready_n
    );
endinterface : adc_link_if

// [hw/adc_device_end.sv]
`timescale 1ns/100ps
module adc_device_end
    import adc_port_pkg::*;
#(
    parameter int UPDATE_CYCLES = UPDATE_CYCLES_DEF,
    parameter int SAMPLE_W = 18
) (
    // Link side
    adc_link_if.dev link,
    // Reset
    input wire logic rst_i,
    // Converter input
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    // User side status
    output logic [7:0] setup_o,
    output logic setup_wr_o,
    output logic standby_o,
    output logic osc_run_o,
    output logic [15:0] result_o
);

    typedef enum logic [2:0] {
        phase_idle,
        phase_cmd,
        phase_read,
        phase_write,
        phase_done
    } phase_type;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_s1;
        logic cs_s2;
        logic din_s1;
        logic din_s2;
        phase_type phase;
        logic [4:0] bitcnt;
        logic [7:0] shreg;
        logic [15:0] out_sr;
        logic dout;
        logic dout_oe;
        logic rdy_n;
        logic [15:0] upd_cnt;
        logic [15:0] result;
        logic [7:0] setup;
        logic setup_wr;
    } state_type;

    localparam logic [15:0] UPD_LAST = 16'(UPDATE_CYCLES - 1);
    localparam logic [15:0] RDY_RAISE = 16'(UPDATE_CYCLES - 1 - RDY_HIGH_CYCLES);

    state_type r;
    state_type next_r;
    logic rise;
    logic fall;
    logic [7:0] in_byte;

    function automatic logic [15:0] clamp_code(input logic signed [SAMPLE_W-1:0] s);
        logic [15:0] code;
        // Offset binary, pinned at either end
        code = s[15:0] ^ CODE_MID;
        if (s > FS_POS) begin
            code = CODE_ALL_ONES;
        end else if (s < FS_NEG) begin
            code = CODE_ALL_ZEROS;
        end
        return code;
    endfunction : clamp_code

    // Edges seen after the synchronisers
    assign rise = r.sclk_s2 & ~r.sclk_d;
    assign fall = ~r.sclk_s2 & r.sclk_d;
    assign in_byte = {r.shreg[6:0], r.din_s2};

    always_comb begin
        next_r = r;
        next_r.sclk_s1 = link.sclk;
        next_r.sclk_s2 = r.sclk_s1;
        next_r.sclk_d = r.sclk_s2;
        next_r.cs_s1 = link.cs_n;
        next_r.cs_s2 = r.cs_s1;
        next_r.din_s1 = link.din;
        next_r.din_s2 = r.din_s1;
        next_r.setup_wr = 1'b0;

        // Serial port
        if (r.cs_s2) begin
            next_r.phase = phase_idle;
            next_r.dout_oe = 1'b0;
            next_r.bitcnt = '0;
        end else begin
            unique case (r.phase)
                phase_idle: begin
                    next_r.phase = phase_cmd;
                    next_r.bitcnt = '0;
                end
                phase_cmd: begin
                    if (rise) begin
                        next_r.shreg = in_byte;
                        next_r.bitcnt = r.bitcnt + 5'h01;
                        if (r.bitcnt == 5'h07) begin
                            next_r.bitcnt = '0;
                            if (in_byte[READ_BIT]) begin
                                next_r.phase = phase_read;
                                next_r.out_sr = r.result;
                            end else begin
                                next_r.phase = phase_write;
                            end
                        end
                    end
                end
                phase_read: begin
                    if (fall) begin
                        next_r.dout = r.out_sr[15];
                        next_r.out_sr = {r.out_sr[14:0], 1'b0};
                        next_r.dout_oe = 1'b1;
                    end
                    if (rise) begin
                        next_r.bitcnt = r.bitcnt + 5'h01;
                        if (r.bitcnt == 5'h0F) begin
                            next_r.dout_oe = 1'b0;
                            next_r.rdy_n = 1'b1;
                            next_r.phase = phase_done;
                        end
                    end
                end
                phase_write: begin
                    if (rise) begin
                        next_r.shreg = in_byte;
                        next_r.bitcnt = r.bitcnt + 5'h01;
                        if (r.bitcnt == 5'h07) begin
                            next_r.setup = in_byte;
                            next_r.setup_wr = 1'b1;
                            next_r.phase = phase_done;
                        end
                    end
                end
                phase_done: begin
                    next_r.dout_oe = 1'b0;
                end
            endcase
        end

        // Output update; a new result wins over a read completing
        if (!r.setup[STBY_BIT]) begin
            if (r.upd_cnt == UPD_LAST) begin
                next_r.upd_cnt = '0;
                next_r.result = clamp_code(sample_i);
                next_r.rdy_n = 1'b0;
            end else begin
                next_r.upd_cnt = r.upd_cnt + 16'h0001;
                if (r.upd_cnt == RDY_RAISE) begin
                    next_r.rdy_n = 1'b1;
                end
            end
        end
    end

    // Reset leaves the lines idle high and the flag high
    always_ff @(posedge link.master_clk or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.sclk_s1 <= 1'b1;
            r.sclk_s2 <= 1'b1;
            r.sclk_d <= 1'b1;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.rdy_n <= 1'b1;
            r.setup <= SETUP_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Link outputs
    assign link.dout = r.dout;
    assign link.dout_oe = r.dout_oe;
    assign link.result_ready_n = r.rdy_n;

    // User side
    assign setup_o = r.setup;
    assign setup_wr_o = r.setup_wr;
    assign standby_o = r.setup[STBY_BIT];
    assign osc_run_o = 1'b1;
    assign result_o = r.result;

endmodule : adc_device_end

// [hw/adc_host_end.sv]
`timescale 1ns/100ps
module adc_result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_type;

    fifo_type r;
    fifo_type next_r;
    logic push;
    logic pop;

    assign in_ready_o = r.count != (AW + 1)'(DEPTH);
    assign out_valid_o = r.count != '0;
    assign out_data_o = r.mem[r.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr] = in_data_i;
            next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + AW'(1);
        end
        if (pop) begin
            next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + AW'(1);
        end
        next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : adc_result_fifo

module adc_host_end
    import adc_port_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF,
    parameter int MCLK_HALF = MCLK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Link side
    adc_link_if.host link,
    // Register writes
    input wire logic wr_req_i,
    input wire logic [7:0] wr_cmd_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ack_o,
    // Result stream
    input wire logic rd_enable_i,
    output logic result_valid_o,
    output logic [15:0] result_data_o,
    input wire logic result_ready_i,
    output logic busy_o
);
    typedef enum logic [2:0] {
        h_idle,
        h_setup,
        h_low,
        h_high,
        h_hold,
        h_gap
    } host_state_type;

    typedef struct packed {
        logic [7:0] mclk_cnt;
        logic mclk;
        logic rdy_s1;
        logic rdy_s2;
        logic dout_s1;
        logic dout_s2;
        host_state_type state;
        logic [9:0] tick;
        logic [4:0] bitcnt;
        logic [4:0] nbits;
        logic is_read;
        logic [15:0] tx;
        logic [15:0] rx;
        logic cs_n;
        logic sclk;
        logic din;
        logic push;
        logic wr_ack;
    } host_type;

    localparam logic MCLK_FAST = (SYS_HZ / (2 * MCLK_HALF)) > CLK_SEL_HZ;
    localparam logic [9:0] HALF_LAST = 10'(SCLK_HALF - 1);
    localparam logic [9:0] SETUP_LAST = 10'(CS_SETUP_CYCLES - 1);
    localparam logic [9:0] GAP_LAST = 10'(2 * SCLK_HALF - 1);

    host_type r;
    host_type next_r;
    logic fifo_ready;
    logic [7:0] wr_byte;

    adc_result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(4)
    ) adc_result_fifo_i (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(r.push),
        .in_data_i(r.rx),
        .in_ready_o(fifo_ready),
        .out_valid_o(result_valid_o),
        .out_data_o(result_data_o),
        .out_ready_i(result_ready_i)
    );

    always_comb begin
        wr_byte = wr_data_i;
        if (wr_cmd_i[REG_LSB +: REG_W] == SETUP_REG) begin
            wr_byte[CLK_BIT] = MCLK_FAST;
        end
    end

    always_comb begin
        next_r = r;
        next_r.rdy_s1 = link.result_ready_n;
        next_r.rdy_s2 = r.rdy_s1;
        next_r.dout_s1 = link.dout_line;
        next_r.dout_s2 = r.dout_s1;
        next_r.wr_ack = 1'b0;
        next_r.tick = r.tick + 10'h001;
        if (r.push && fifo_ready) begin
            next_r.push = 1'b0;
        end

        // Free-running master clock, even duty
        if (r.mclk_cnt == 8'(MCLK_HALF - 1)) begin
            next_r.mclk_cnt = '0;
            next_r.mclk = ~r.mclk;
        end else begin
            next_r.mclk_cnt = r.mclk_cnt + 8'h01;
        end

        unique case (r.state)
            h_idle: begin
                next_r.tick = '0;
                next_r.bitcnt = '0;
                if (wr_req_i) begin
                    next_r.tx = {wr_cmd_i & ~(8'h01 << READ_BIT), wr_byte};
                    next_r.nbits = 5'h10;
                    next_r.is_read = 1'b0;
                    next_r.wr_ack = 1'b1;
                    next_r.cs_n = 1'b0;
                    next_r.state = h_setup;
                end else if (rd_enable_i && !r.rdy_s2 && fifo_ready && !r.push) begin
                    next_r.tx = {READ_CMD, 8'h00};
                    next_r.nbits = 5'h18;
                    next_r.is_read = 1'b1;
                    next_r.cs_n = 1'b0;
                    next_r.state = h_setup;
                end
            end
            h_setup: begin
                if (r.tick == SETUP_LAST) begin
                    next_r.tick = '0;
                    next_r.sclk = 1'b0;
                    next_r.din = r.tx[15];
                    next_r.tx = {r.tx[14:0], 1'b0};
                    next_r.state = h_low;
                end
            end
            h_low: begin
                if (r.tick == HALF_LAST) begin
                    next_r.tick = '0;
                    next_r.sclk = 1'b1;
                    if (r.is_read && r.bitcnt >= 5'h08) begin
                        next_r.rx = {r.rx[14:0], r.dout_s2};
                    end
                    next_r.state = h_high;
                end
            end
            h_high: begin
                if (r.tick == HALF_LAST) begin
                    next_r.tick = '0;
                    next_r.bitcnt = r.bitcnt + 5'h01;
                    if (r.bitcnt == r.nbits - 5'h01) begin
                        next_r.state = h_hold;
                    end else begin
                        next_r.sclk = 1'b0;
                        next_r.din = r.tx[15];
                        next_r.tx = {r.tx[14:0], 1'b0};
                        next_r.state = h_low;
                    end
                end
            end
            h_hold: begin
                if (r.tick == HALF_LAST) begin
                    next_r.tick = '0;
                    next_r.cs_n = 1'b1;
                    next_r.push = r.is_read;
                    next_r.state = h_gap;
                end
            end
            h_gap: begin
                if (r.tick == GAP_LAST) begin
                    next_r.state = h_idle;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.rdy_s1 <= 1'b1;
            r.rdy_s2 <= 1'b1;
            r.cs_n <= 1'b1;
            r.sclk <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.master_clk = r.mclk;
    assign link.cs_n = r.cs_n;
    assign link.sclk = r.sclk;
    assign link.din = r.din;
    assign wr_ack_o = r.wr_ack;
    assign busy_o = r.state != h_idle;
endmodule : adc_host_end

// [test/adc_link_sva.sv]
`timescale 1ns/100ps
module adc_link_sva
    import adc_port_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Link
    input wire logic master_clk,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic dout_line,
    input wire logic result_ready_n
);
    logic mclk_q;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [9:0] high_cnt;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // Frame bit count and ready-high time
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mclk_q <= 1'b0;
            sclk_q <= 1'b1;
            bit_cnt <= 5'h00;
            high_cnt <= 10'h000;
        end else begin
            mclk_q <= master_clk;
            sclk_q <= sclk;
            if (cs_n) begin
                bit_cnt <= 5'h00;
            end else if (sclk && !sclk_q) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (result_ready_n == 1'b0) begin
                high_cnt <= 10'h000;
            end else if (master_clk && !mclk_q && high_cnt != 10'h3FF) begin
                high_cnt <= high_cnt + 10'h001;
            end
        end
    end

    a_dout_after_fall: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
        else $error("data out changed while serial clock high");
    a_release_by_end: assert property ($rose(cs_n) |-> !dout_oe)
        else $error("data out still driven at end of frame");
    a_hold_to_last: assert property ($fell(dout_oe) |-> bit_cnt == 5'h18)
        else $error("data out released before last rise");
    a_select_before_rise: assert property ($rose(sclk) |-> !cs_n && !$past(cs_n, CS_SETUP_CYCLES))
        else $error("serial clock rose without select setup");
    a_no_idle_fall: assert property ($fell(sclk) |-> !cs_n)
        else $error("serial clock fell outside frame");
    a_select_past_rise: assert property ($rose(cs_n) |-> $past(sclk, 2) && sclk)
        else $error("select rose too close to serial clock rise");
    a_din_held: assert property ($rose(sclk) && !cs_n |-> $past(din, 2) == din ##1 $stable(din))
        else $error("data in moved around serial clock rise");
    a_ready_high_time: assert property ($fell(result_ready_n) |-> high_cnt >= 10'h1F3)
        else $error("ready flag high time too short");
    a_ready_after_read: assert property ($rose(cs_n) && bit_cnt == 5'h18 |-> result_ready_n)
        else $error("ready flag not high after read");

    c_write_frame: cover property ($rose(cs_n) && bit_cnt == 5'h10);
    c_read_frame: cover property ($rose(cs_n) && bit_cnt == 5'h18);
    c_update: cover property ($fell(result_ready_n));
    c_line_low: cover property (dout_oe && !dout_line);
endmodule : adc_link_sva

// [test/tb_adc_serial_port_ready_logic.sv]
`timescale 1ns/100ps
module tb_adc_serial_port_ready_logic;
    import adc_port_pkg::*;
    localparam int UPD = 520;
    localparam int HALF = 60;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic wr_req_i = 1'b0;
    logic [7:0] wr_cmd_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic rd_enable_i = 1'b0;
    logic result_ready_i = 1'b1;
    logic signed [17:0] sample_i = 18'h0_7FFF;
    logic wr_ack_o, result_valid_o, busy_o, setup_wr_o, standby_o, osc_run_o;
    logic [15:0] result_data_o, result_o, cur_code;
    logic [7:0] setup_o, set_exp;
    logic signed [17:0] vals [8];
    logic [15:0] exp_q [$];
    logic [15:0] wire_q [$];
    logic [7:0] setup_q [$];
    logic [23:0] din_sh, dl_sh;
    logic sclk_q = 1'b1, cs_q = 1'b1, rrn_q = 1'b1;
    int nbits, rd_frames, base, cyc, miscompares, tests_run;

    always #12.5 sys_clk_i = ~sys_clk_i;

    adc_link_if adc_link_if_i ();
    adc_host_end #(.SCLK_HALF(HALF)) adc_host_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .link(adc_link_if_i.host), .wr_req_i(wr_req_i), .wr_cmd_i(wr_cmd_i), .wr_data_i(wr_data_i),
        .wr_ack_o(wr_ack_o), .rd_enable_i(rd_enable_i), .result_valid_o(result_valid_o),
        .result_data_o(result_data_o), .result_ready_i(result_ready_i), .busy_o(busy_o));
    adc_device_end #(.UPDATE_CYCLES(UPD)) adc_device_end_i (.link(adc_link_if_i.dev), .rst_i(rst_i),
        .sample_i(sample_i), .setup_o(setup_o), .setup_wr_o(setup_wr_o), .standby_o(standby_o),
        .osc_run_o(osc_run_o), .result_o(result_o));
    adc_link_sva adc_link_sva_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .master_clk(adc_link_if_i.master_clk),
        .cs_n(adc_link_if_i.cs_n), .sclk(adc_link_if_i.sclk), .din(adc_link_if_i.din),
        .dout(adc_link_if_i.dout), .dout_oe(adc_link_if_i.dout_oe), .dout_line(adc_link_if_i.dout_line),
        .result_ready_n(adc_link_if_i.result_ready_n));

    function automatic logic [15:0] code_of(input logic signed [17:0] s);
        int v;
        v = s;
        if (v > FS_POS) return CODE_ALL_ONES;
        if (v < FS_NEG) return CODE_ALL_ZEROS;
        return 16'(v - FS_NEG);
    endfunction : code_of

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic do_write(input logic [7:0] cmd, input logic [7:0] data);
        int n;
        setup_q.push_back(data | (8'h01 << CLK_BIT));
        wire_q.push_back({cmd & ~(8'h01 << READ_BIT), data | (8'h01 << CLK_BIT)});
        @(posedge sys_clk_i);
        wr_cmd_i <= cmd;
        wr_data_i <= data;
        wr_req_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wr_ack_o !== 1'b1 && n < 20000);
        check("write ack", 24'h1, 24'(wr_ack_o));
        wr_req_i <= 1'b0;
        while (setup_q.size() != 0 && n < 30000) begin
            @(posedge sys_clk_i);
            n++;
        end
        check("setup seen", 24'h0, 24'(setup_q.size()));
    endtask : do_write

    initial begin
        rst_i <= 1'b1;
        vals = '{18'h0_7FFF, 18'h0_8000, 18'h3_8000, 18'h3_7FFF, 18'h1_FFFF, 18'h2_0000, 18'h0_0000, 18'h0_0000};
        void'($urandom(32'h1C38_F1AC));
        vals[6] = 18'($urandom);
        vals[7] = 18'($urandom);
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        check("cs_n idle", 24'h1, adc_link_if_i.cs_n);
        check("sclk idle", 24'h1, adc_link_if_i.sclk);
        check("ready idle", 24'h1, adc_link_if_i.result_ready_n);
        check("busy idle", 24'h0, busy_o);
        $display("test reset done");
        do_write(8'h18, 8'($urandom) & 8'hBF);
        $display("test setup write done");
        rd_enable_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge adc_link_if_i.result_ready_n);
            @(posedge sys_clk_i);
            check("result word", code_of(sample_i), result_o);
            if (i < 7) sample_i <= vals[i + 1];
            if (i == 3) begin
                result_ready_i <= 1'b0;
                base = rd_frames;
            end
        end
        @(posedge adc_link_if_i.result_ready_n);
        check("reads while full", 24'h4, 24'(rd_frames - base));
        result_ready_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        check("drained", 24'h0, 24'(exp_q.size()));
        check("fifo empty", 24'h0, result_valid_o);
        $display("test stream and back-pressure done");
        do_write(8'h10, 8'h40 | 8'($urandom));
        $display("test standby write done");
        give_verdict();
    end

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 95000) begin
            miscompares++;
            give_verdict();
        end
        if (result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
            if (exp_q.size() == 0) check("extra result", 24'h0, 24'h1);
            else check("result", exp_q.pop_front(), result_data_o);
        end
        if (rrn_q === 1'b1 && adc_link_if_i.result_ready_n === 1'b0) cur_code = code_of(sample_i);
        if (!adc_link_if_i.cs_n && adc_link_if_i.sclk && !sclk_q) begin
            din_sh = {din_sh[22:0], adc_link_if_i.din};
            dl_sh = {dl_sh[22:0], adc_link_if_i.dout_line};
            nbits++;
        end
        if (adc_link_if_i.cs_n && !cs_q) begin
            if (nbits == 16) begin
                check("write bits", wire_q.pop_front(), din_sh[15:0]);
            end else begin
                check("read command", READ_CMD, din_sh[23:16]);
                check("read bits", cur_code, dl_sh[15:0]);
                exp_q.push_back(cur_code);
                rd_frames++;
            end
            nbits = 0;
        end
        sclk_q = adc_link_if_i.sclk;
        cs_q = adc_link_if_i.cs_n;
        rrn_q = adc_link_if_i.result_ready_n;
    end

    always @(posedge adc_link_if_i.master_clk) begin
        if (setup_wr_o === 1'b1) begin
            set_exp = setup_q.pop_front();
            check("setup", set_exp, setup_o);
            check("standby", set_exp[STBY_BIT], standby_o);
            check("oscillator", 24'h1, osc_run_o);
        end
    end
endmodule : tb_adc_serial_port_ready_logic
